//--- irq_pin_gpio_pullup_ctrl_bench.sv
// Purpose: self-checking bench for the pin and interrupt control block
// Assumes: 250 MHz clock, register port driven by the host model
// Notes: random data from a fixed xorshift seed, corners by hand
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
	mismatches++; $display("Error at %0t: got %h want %h", $time, g, e); \
	end end
module irq_pin_gpio_pullup_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 0, rst_n = 0, chip_reset_n = 1, sense = 0, att = 0;
	logic bact = 0, sof = 0, reg_wr, pu, dppd, dmpd, irq_o, irq_oe;
	logic aux_out, operate;
	logic [4:0] reg_addr;
	logic [7:0] gin = 0, rv, d, reg_wdata, reg_rdata, gen_outputs;
	logic [31:0] rng = 40, x;
	logic [4:0] ra [8] = '{5'h0f, 5'h10, 5'h11, 5'h12, 5'h16, 5'h17,
		5'h18, 5'h1b};
	int mismatches = 0, check_count = 0, n, m;
	////////////////////////////////////////////////////////////
	pgc_pin_ctrl #(.CW(12)) u_pgc_pin_ctrl (.clock(clock), .rst_n(rst_n),
		.chip_reset_n(chip_reset_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.bus_power_sense_pin(sense), .dev_attached(att),
		.engine_irq(1'b0), .bus_activity(bact), .sof_wave(sof),
		.gen_inputs(gin), .gen_outputs(gen_outputs),
		.dplus_pullup_en(pu), .dplus_pulldown_en(dppd),
		.dminus_pulldown_en(dmpd), .irq_o(irq_o), .irq_oe(irq_oe),
		.aux_out(aux_out), .operate(operate));
	pgc_host_model u_pgc_host_model (.clock(clock), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	////////////////////////////////////////////////////////////
	function logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	// pulse cycles: width in ns at 4 ns a cycle
	function int wexp(input [1:0] s);
		int ns [4] = '{10600, 5300, 2600, 1300};
		return ns[s] / 4;
	endfunction
	task w(input [4:0] a, input [7:0] v);
		u_pgc_host_model.wr(a, v, int'(xs() % 3));
	endtask
	task r(input [4:0] a);
		u_pgc_host_model.rd(a, rv);
	endtask
	task tk(input int k);
		repeat (k) @(posedge clock);
	endtask
	task cut(input bit hit);
		if (hit) begin
			mismatches++;
			test_done();
		end
	endtask
	// waits at most 20 cycles for the pin at level v
	task wait_pin(input logic v);
		n = 0;
		while (irq_o !== v && n < 20) begin
			@(posedge clock);
			n++;
		end
		cut(n == 20);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		forever #2 clock = ~clock;
	end
	initial begin
		tk(20);
		rst_n <= 1'b1;
		tk(4);
		for (int i = 0; i < 8; i++) begin
			r(ra[i]);
			`CHK(rv, 8'h00)
		end
		// pull-up truth table: connect, gate, sensed power
		for (int i = 0; i < 8; i++) begin
			d = i;
			w(5'h0f, {1'b0, d[1], 2'h0, d[0], 3'h0});
			sense <= d[2];
			tk(6);
			`CHK(pu, d[0] & (~d[1] | d[2]))
			r(5'h0f);
			`CHK(rv[0], d[2])
		end
		// outputs keep stored bits, upper nibbles show inputs
		for (int i = 0; i < 6; i++) begin
			x = xs();
			w(5'h14, x[7:0]);
			w(5'h15, x[15:8]);
			gin <= x[23:16];
			tk(5);
			`CHK(gen_outputs, {x[11:8], x[3:0]})
			r(5'h14);
			`CHK(rv, {x[19:16], x[3:0]})
			r(5'h15);
			`CHK(rv, {x[23:20], x[11:8]})
		end
		// disabled pin idles at each mode's inactive level
		w(5'h11, 8'h08);
		tk(3);
		`CHK(irq_oe, 1'b0)
		w(5'h11, 8'h00);
		tk(3);
		`CHK({irq_oe, irq_o}, 2'b11)
		w(5'h11, 8'h04);
		tk(3);
		`CHK({irq_oe, irq_o}, 2'b10)
		// level mode with two pending flags, cleared one by one
		gin <= 8'h00;
		w(5'h18, 8'h01);
		w(5'h17, 8'h03);
		w(5'h16, 8'hff);
		w(5'h10, 8'h01);
		w(5'h11, 8'h0c);
		gin <= 8'h03;
		tk(8);
		`CHK({irq_oe, irq_o}, 2'b10)
		r(5'h16);
		`CHK(rv, 8'h01)
		gin <= 8'h01;
		tk(8);
		w(5'h16, 8'h01);
		tk(4);
		`CHK({irq_oe, irq_o}, 2'b10)
		w(5'h16, 8'h02);
		tk(4);
		`CHK(irq_oe, 1'b0)
		// edge mode: every width code, polarity alternating
		for (int s = 0; s < 4; s++) begin
			d = s;
			w(5'h10, {d[1:0], 6'h01});
			w(5'h11, {5'h0, d[0], 2'h0});
			gin <= 8'h00;
			tk(4);
			w(5'h16, 8'hff);
			gin <= 8'h01;
			wait_pin(d[0]);
			`CHK(irq_oe, 1'b1)
			m = 0;
			while (irq_o === d[0] && m < 4000) begin
				@(posedge clock);
				m++;
			end
			`CHK(m, wexp(d[1:0]))
		end
		// clearing one request while another pends pulses again
		gin <= 8'h03;
		tk(3);
		gin <= 8'h01;
		tk(400);
		w(5'h16, 8'h02);
		wait_pin(1'b1);
		`CHK(irq_o, 1'b1)
		tk(400);
		// split input requests onto aux in level mode
		w(5'h1b, 8'h10);
		w(5'h11, 8'h0a);
		gin <= 8'h00;
		tk(4);
		w(5'h16, 8'hff);
		gin <= 8'h01;
		tk(8);
		`CHK({aux_out, irq_oe}, 2'b00)
		w(5'h16, 8'hff);
		tk(4);
		`CHK(aux_out, 1'b1)
		// aux select codes with random source levels
		w(5'h1b, 8'h00);
		for (int k = 0; k < 4; k++) begin
			x = xs();
			sense <= x[1];
			bact <= x[2];
			sof <= x[3];
			d = k;
			w(5'h11, {6'h0, d[1:0]});
			tk(4);
			`CHK(aux_out, 1'(k == 0) | x[k])
		end
		// host pulldowns, then attach and power events
		for (int k = 0; k < 4; k++) begin
			d = k;
			w(5'h1b, {d[1:0], 6'h01});
			tk(4);
			`CHK({dmpd, dppd}, d[1:0])
		end
		w(5'h0e, 8'h03);
		w(5'h0d, 8'h03);
		att <= 1'b1;
		sense <= ~sense;
		tk(6);
		r(5'h0d);
		`CHK(rv[1:0], 2'b11)
		// chip reset keeps pin and usb control, clears the rest
		w(5'h11, 8'h09);
		w(5'h14, 8'h0f);
		chip_reset_n <= 1'b0;
		tk(4);
		`CHK({operate, gen_outputs[3:0]}, 5'h00)
		r(5'h10);
		`CHK(rv, 8'h00)
		r(5'h11);
		`CHK(rv, 8'h09)
		chip_reset_n <= 1'b1;
		tk(6);
		`CHK(operate, 1'b1)
		test_done();
	end
endmodule

//--- pgc_defines.vh
// Purpose: shared constants of the pin, gpio and interrupt control block
// Assumes: included by every design file of the block
// Notes: offsets are register indices on the internal register port
// Contract
// - pull-up needs connect and gated bus power
// - bus power readable and raises an event
// - two mode bits drive the two pulldowns
// - host mode flags attach and detach
// - chip reset clears all but two registers
// - single clock edge drives all logic
// - interrupt pin active only with global enable
// - disabled pin rests in its inactive level
// - level mode holds low while flags pend
// - level mode ignores the polarity bit
// - edge mode pulses on new or partial clear
// - polarity bit picks pulse level in edge mode
// - two-bit field picks one of four widths
// - upper nibbles read inputs, writes ignored
// - input flags and enables merge into interrupt
// - per-input polarity picks the flag edge
// - split bit routes input interrupts to aux when aux select is on the activity code
// - lower nibbles drive outputs, read back stored
// - two select bits steer the aux multiplexer
// - select codes: operate, power, activity, frame
// - split inputs leave the main interrupt
`ifndef PGC_DEFINES_VH
`define PGC_DEFINES_VH
// register indices
`define PGC_A_USB_FLAGS 5'h0d
`define PGC_A_USB_EN 5'h0e
`define PGC_A_USB_CTL 5'h0f
`define PGC_A_CPU_CTL 5'h10
`define PGC_A_PIN_CTL 5'h11
`define PGC_A_IO_LO 5'h14
`define PGC_A_IO_HI 5'h15
`define PGC_A_GIN_FLAGS 5'h16
`define PGC_A_GIN_EN 5'h17
`define PGC_A_GIN_POL 5'h18
`define PGC_A_MODE 5'h1b
// field positions
`define PGC_B_POWER_SEEN 0
`define PGC_B_CONNECT 3
`define PGC_B_GATE 6
`define PGC_B_GIE 0
`define PGC_B_WID_LO 6
`define PGC_B_WID_HI 7
`define PGC_B_SEL_LO 0
`define PGC_B_SEL_HI 1
`define PGC_B_ACT_HIGH 2
`define PGC_B_LEVEL 3
`define PGC_B_HOST 0
`define PGC_B_SPLIT 4
`define PGC_B_DP_PD 6
`define PGC_B_DM_PD 7
`define PGC_B_EV_POWER 0
`define PGC_B_EV_ATTACH 1
// reset values and aux select codes
`define PGC_RST8 8'h00
`define PGC_RST4 4'h0
`define PGC_RST2 2'h0
`define PGC_SEL_OPERATE 2'h0
`define PGC_SEL_POWER 2'h1
`define PGC_SEL_ACTIVITY 2'h2
`define PGC_SEL_FRAME 2'h3
// timing: clock rate and pulse widths in ns
`define PGC_CLK_MHZ 250
`define PGC_W00_NS 10600
`define PGC_W01_NS 5300
`define PGC_W10_NS 2600
`define PGC_W11_NS 1300
`define PGC_CYC(ns) ((ns) * `PGC_CLK_MHZ / 1000)
`endif

//--- pgc_edge_det.v
// Purpose: per-input edge events for the general inputs
// Assumes: inputs already synchronous to clock
// Notes: one-cycle event pulses, registered
`include "pgc_defines.vh"
module pgc_edge_det #(
	parameter N = 8
) (
	input wire clock,
	input wire rst_n,
	input wire [N-1:0] din,
	input wire [N-1:0] rise_sel,
	output reg [N-1:0] hit
);
	reg [N-1:0] prev_r; // last sampled level
	// two-stage arm: the first history sample after reset still holds
	// the sampler's reset value, so an input idling high would
	// otherwise fake a rising edge
	reg [1:0] armed_r;
	wire [N-1:0] ev; // raw edge per bit
	genvar i;
	////////////////////////////////////////////////////////////////
	// polarity bit 1 takes rising, 0 takes falling
	generate
		for (i = 0; i < N; i = i + 1) begin : g_bit
			assign ev[i] = rise_sel[i] ? (din[i] & ~prev_r[i]) :
				(~din[i] & prev_r[i]);
		end
	endgenerate
	////////////////////////////////////////////////////////////////
	// history and event register
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prev_r <= {N{1'b0}};
			armed_r <= 2'h0;
			hit <= {N{1'b0}};
		end else begin
			prev_r <= din;
			armed_r <= {armed_r[0], 1'b1};
			hit <= armed_r[1] ? ev : {N{1'b0}};
		end
	end
endmodule

//--- pgc_host_model.sv
// Purpose: register master on the far side of the register port
// Assumes: requests launched just after a rising edge
// Notes: write data is scrambled when idle so stale data never helps
module pgc_host_model (
	input wire clock,
	output logic [4:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	input wire [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////
	initial begin
		reg_addr = 5'h1f;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
	end
	// one-cycle write strobe, then an optional slow gap
	task wr(input [4:0] a, input [7:0] v, input int gap);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_wdata <= ~v;
		repeat (gap) @(posedge clock);
	endtask
	// read answers one cycle after the index is taken; wait with margin
	task rd(input [4:0] a, output [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		repeat (3) @(posedge clock);
		v = reg_rdata;
	endtask
endmodule

//--- pgc_irq_gen.v
// Purpose: level or pulse interrupt pin driver
// Assumes: req holds enabled pending requests, one bit each
// Notes: a new event during a pulse restarts its width
`include "pgc_defines.vh"
module pgc_irq_gen #(
	parameter NREQ = 8,
	parameter CW = 12
) (
	input wire clock,
	input wire rst_n,
	input wire [NREQ-1:0] req,
	input wire enable,
	input wire level_mode,
	input wire active_high,
	input wire [1:0] width_sel,
	output reg pin_o,
	output reg pin_oe
);
	localparam [31:0] C00 = `PGC_CYC(`PGC_W00_NS);
	localparam [31:0] C01 = `PGC_CYC(`PGC_W01_NS);
	localparam [31:0] C10 = `PGC_CYC(`PGC_W10_NS);
	localparam [31:0] C11 = `PGC_CYC(`PGC_W11_NS);
	reg [NREQ-1:0] req_q; // requests one cycle ago
	reg [CW-1:0] cnt_r; // cycles of pulse left
	reg [CW-1:0] cnt_nxt;
	wire any = |req;
	wire start = (|(req & ~req_q)) |
		((|(req_q & ~req)) & any);
	////////////////////////////////////////////////////////////////
	// width code to whole cycle count
	function [CW-1:0] width_cycles;
		input [1:0] s;
		begin
			case (s)
				2'h0: width_cycles = C00[CW-1:0];
				2'h1: width_cycles = C01[CW-1:0];
				2'h2: width_cycles = C10[CW-1:0];
				default: width_cycles = C11[CW-1:0];
			endcase
		end
	endfunction
	////////////////////////////////////////////////////////////////
	// pulse counter next value
	always @* begin
		cnt_nxt = cnt_r;
		if (!enable || level_mode)
			cnt_nxt = {CW{1'b0}};
		else if (start)
			cnt_nxt = width_cycles(width_sel);
		else if (cnt_r != {CW{1'b0}})
			cnt_nxt = cnt_r - 1'b1;
	end
	////////////////////////////////////////////////////////////////
	// pin drive; idle edge mode, active low, is high
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			req_q <= {NREQ{1'b0}};
			cnt_r <= {CW{1'b0}};
			pin_o <= 1'b1;
			pin_oe <= 1'b1;
		end else begin
			req_q <= req;
			cnt_r <= cnt_nxt;
			if (level_mode) begin
				pin_o <= 1'b0;
				pin_oe <= enable & any;
			end else begin
				pin_oe <= 1'b1;
				pin_o <= (cnt_nxt != {CW{1'b0}}) ?
					active_high : ~active_high;
			end
		end
	end
endmodule

//--- pgc_pin_ctrl.v
// Purpose: pin, gpio, pull resistor and interrupt control
// Assumes: register port driven by the serial slave logic
// Notes: all outputs registered; chip reset is sampled
`include "pgc_defines.vh"
module pgc_pin_ctrl #(
	parameter CW = 12
) (
	input wire clock,
	input wire rst_n,
	input wire chip_reset_n,
	input wire [4:0] reg_addr,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	input wire bus_power_sense_pin,
	input wire dev_attached,
	input wire engine_irq,
	input wire bus_activity,
	input wire sof_wave,
	input wire [7:0] gen_inputs,
	output reg [7:0] gen_outputs,
	output reg dplus_pullup_en,
	output reg dplus_pulldown_en,
	output reg dminus_pulldown_en,
	output wire irq_o,
	output wire irq_oe,
	output reg aux_out,
	output reg operate
);
	////////////////////////////////////////////////////////////////
	// declarations
	reg rs1_r; // reset synchroniser first stage
	reg rs2_r; // reset synchroniser second stage
	wire rst_sync_n = rs2_r; // released reset for the block
	reg chip_rst_r; // sampled chip reset, high = in reset
	reg bus_power_present; // sampled comparator output
	reg power_q; // previous comparator sample
	reg attach_r; // sampled attach level
	reg attach_q; // previous attach sample
	reg [7:0] gin_r; // sampled general inputs
	reg [7:0] usb_ctl_r; // usb_control, survives chip reset
	reg [7:0] cpu_ctl_r; // cpu_control
	reg [7:0] pin_ctl_r; // pin_control, survives chip reset
	reg [3:0] out_lo_r; // stored outputs 3..0
	reg [3:0] out_hi_r; // stored outputs 7..4
	reg [7:0] gin_flags_r; // input_irq_flags
	reg [7:0] gin_en_r; // input_irq_enables
	reg [7:0] gin_pol_r; // input_irq_polarity
	reg [7:0] mode_r; // operating_mode
	reg [1:0] usb_flags_r; // power and attach event flags
	reg [1:0] usb_en_r; // their enables
	reg [7:0] rdata_nxt; // read mux result
	reg aux_nxt; // aux mux result
	wire [7:0] gin_hit; // input edge events
	wire [1:0] usb_set; // event set terms
	wire [7:0] gin_pend; // enabled pending input flags
	wire split_on; // inputs routed to aux
	wire [10:0] main_req; // requests of the main pin
	wire [7:0] aux_req; // requests of the aux interrupt
	wire aux_o; // aux interrupt level
	wire aux_oe; // aux interrupt drive
	wire host = mode_r[`PGC_B_HOST];
	wire [1:0] aux_sel = {pin_ctl_r[`PGC_B_SEL_HI],
		pin_ctl_r[`PGC_B_SEL_LO]};
	wire [1:0] width_sel = {cpu_ctl_r[`PGC_B_WID_HI],
		cpu_ctl_r[`PGC_B_WID_LO]};

	////////////////////////////////////////////////////////////////
	// write strobe decode for one register
	function wr_hit;
		input [4:0] a;
		input [4:0] ra;
		input we;
		begin
			wr_hit = we && (ra == a);
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// reset release through two flops; async assert
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rs1_r <= 1'b0;
			rs2_r <= 1'b0;
		end else begin
			rs1_r <= 1'b1;
			rs2_r <= rs1_r;
		end
	end

	////////////////////////////////////////////////////////////////
	// input sampling, one clock edge only
	always @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			chip_rst_r <= 1'b0;
			bus_power_present <= 1'b0;
			power_q <= 1'b0;
			attach_r <= 1'b0;
			attach_q <= 1'b0;
			gin_r <= `PGC_RST8;
		end else begin
			chip_rst_r <= ~chip_reset_n;
			bus_power_present <= bus_power_sense_pin;
			power_q <= bus_power_present;
			attach_r <= dev_attached;
			attach_q <= attach_r;
			gin_r <= gen_inputs;
		end
	end

	////////////////////////////////////////////////////////////////
	// input edge detection per polarity bit
	pgc_edge_det #(
		.N(8)
	) u_edge (
		.clock(clock),
		.rst_n(rst_sync_n),
		.din(gin_r),
		.rise_sel(gin_pol_r),
		.hit(gin_hit)
	);

	// power seen or lost; attach change only counts in host mode
	assign usb_set[`PGC_B_EV_POWER] = bus_power_present ^ power_q;
	assign usb_set[`PGC_B_EV_ATTACH] = host & (attach_r ^ attach_q);

	////////////////////////////////////////////////////////////////
	// registers kept through chip reset
	always @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			usb_ctl_r <= `PGC_RST8;
			pin_ctl_r <= `PGC_RST8;
		end else begin
			// status bit 0 of usb_control is read-only
			if (wr_hit(`PGC_A_USB_CTL, reg_addr, reg_wr))
				usb_ctl_r <= reg_wdata;
			if (wr_hit(`PGC_A_PIN_CTL, reg_addr, reg_wr))
				pin_ctl_r <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// registers returned to defaults by chip reset
	always @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cpu_ctl_r <= `PGC_RST8;
			out_lo_r <= `PGC_RST4;
			out_hi_r <= `PGC_RST4;
			gin_flags_r <= `PGC_RST8;
			gin_en_r <= `PGC_RST8;
			gin_pol_r <= `PGC_RST8;
			mode_r <= `PGC_RST8;
			usb_flags_r <= `PGC_RST2;
			usb_en_r <= `PGC_RST2;
		end else if (chip_rst_r) begin
			// held in defaults while the reset pin is low
			cpu_ctl_r <= `PGC_RST8;
			out_lo_r <= `PGC_RST4;
			out_hi_r <= `PGC_RST4;
			gin_flags_r <= `PGC_RST8;
			gin_en_r <= `PGC_RST8;
			gin_pol_r <= `PGC_RST8;
			mode_r <= `PGC_RST8;
			usb_flags_r <= `PGC_RST2;
			usb_en_r <= `PGC_RST2;
		end else begin
			if (wr_hit(`PGC_A_CPU_CTL, reg_addr, reg_wr))
				cpu_ctl_r <= reg_wdata;
			// only the low nibble is stored; inputs ignore writes
			if (wr_hit(`PGC_A_IO_LO, reg_addr, reg_wr))
				out_lo_r <= reg_wdata[3:0];
			if (wr_hit(`PGC_A_IO_HI, reg_addr, reg_wr))
				out_hi_r <= reg_wdata[3:0];
			if (wr_hit(`PGC_A_GIN_EN, reg_addr, reg_wr))
				gin_en_r <= reg_wdata;
			if (wr_hit(`PGC_A_GIN_POL, reg_addr, reg_wr))
				gin_pol_r <= reg_wdata;
			if (wr_hit(`PGC_A_MODE, reg_addr, reg_wr))
				mode_r <= reg_wdata;
			if (wr_hit(`PGC_A_USB_EN, reg_addr, reg_wr))
				usb_en_r <= reg_wdata[1:0];
			// write one to clear; a new event in the same cycle wins
			if (wr_hit(`PGC_A_GIN_FLAGS, reg_addr, reg_wr))
				gin_flags_r <= (gin_flags_r & ~reg_wdata) | gin_hit;
			else
				gin_flags_r <= gin_flags_r | gin_hit;
			if (wr_hit(`PGC_A_USB_FLAGS, reg_addr, reg_wr))
				usb_flags_r <= (usb_flags_r & ~reg_wdata[1:0]) |
					usb_set;
			else
				usb_flags_r <= usb_flags_r | usb_set;
		end
	end

	////////////////////////////////////////////////////////////////
	// interrupt routing
	// split only takes effect with aux select on the activity code
	assign split_on = mode_r[`PGC_B_SPLIT] &
		(aux_sel == `PGC_SEL_ACTIVITY);
	assign gin_pend = gin_flags_r & gin_en_r;
	assign main_req = {engine_irq, usb_flags_r & usb_en_r,
		split_on ? 8'h00 : gin_pend};
	assign aux_req = split_on ? gin_pend : 8'h00;

	// main interrupt pin
	pgc_irq_gen #(
		.NREQ(11),
		.CW(CW)
	) u_irq_main (
		.clock(clock),
		.rst_n(rst_sync_n),
		.req(main_req),
		.enable(cpu_ctl_r[`PGC_B_GIE]),
		.level_mode(pin_ctl_r[`PGC_B_LEVEL]),
		.active_high(pin_ctl_r[`PGC_B_ACT_HIGH]),
		.width_sel(width_sel),
		.pin_o(irq_o),
		.pin_oe(irq_oe)
	);

	// input interrupt for aux, same settings as the main pin
	pgc_irq_gen #(
		.NREQ(8),
		.CW(CW)
	) u_irq_aux (
		.clock(clock),
		.rst_n(rst_sync_n),
		.req(aux_req),
		.enable(cpu_ctl_r[`PGC_B_GIE]),
		.level_mode(pin_ctl_r[`PGC_B_LEVEL]),
		.active_high(pin_ctl_r[`PGC_B_ACT_HIGH]),
		.width_sel(width_sel),
		.pin_o(aux_o),
		.pin_oe(aux_oe)
	);

	////////////////////////////////////////////////////////////////
	// aux multiplexer; aux is push-pull, so a released
	// level-mode interrupt shows as high
	always @* begin
		case (aux_sel)
			`PGC_SEL_OPERATE: aux_nxt = rst_sync_n & ~chip_rst_r;
			`PGC_SEL_POWER: aux_nxt = bus_power_present;
			`PGC_SEL_ACTIVITY: aux_nxt = split_on ?
				(aux_oe ? aux_o : 1'b1) : bus_activity;
			`PGC_SEL_FRAME: aux_nxt = sof_wave;
			default: aux_nxt = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// read mux; unmapped indices read zero
	always @* begin
		case (reg_addr)
			`PGC_A_USB_FLAGS: rdata_nxt = {6'h00, usb_flags_r};
			`PGC_A_USB_EN: rdata_nxt = {6'h00, usb_en_r};
			`PGC_A_USB_CTL: rdata_nxt = {usb_ctl_r[7:1],
				bus_power_present};
			`PGC_A_CPU_CTL: rdata_nxt = cpu_ctl_r;
			`PGC_A_PIN_CTL: rdata_nxt = pin_ctl_r;
			`PGC_A_IO_LO: rdata_nxt = {gin_r[3:0], out_lo_r};
			`PGC_A_IO_HI: rdata_nxt = {gin_r[7:4], out_hi_r};
			`PGC_A_GIN_FLAGS: rdata_nxt = gin_flags_r;
			`PGC_A_GIN_EN: rdata_nxt = gin_en_r;
			`PGC_A_GIN_POL: rdata_nxt = gin_pol_r;
			`PGC_A_MODE: rdata_nxt = mode_r;
			default: rdata_nxt = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// registered pin outputs and read data
	always @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			reg_rdata <= 8'h00;
			gen_outputs <= `PGC_RST8;
			dplus_pullup_en <= 1'b0;
			dplus_pulldown_en <= 1'b0;
			dminus_pulldown_en <= 1'b0;
			aux_out <= 1'b0;
			operate <= 1'b0;
		end else begin
			reg_rdata <= rdata_nxt;
			gen_outputs <= {out_hi_r, out_lo_r};
			// gate off only when gating is on and power is absent
			dplus_pullup_en <= usb_ctl_r[`PGC_B_CONNECT] &
				(~usb_ctl_r[`PGC_B_GATE] | bus_power_present);
			dplus_pulldown_en <= mode_r[`PGC_B_DP_PD];
			dminus_pulldown_en <= mode_r[`PGC_B_DM_PD];
			aux_out <= aux_nxt;
			operate <= ~chip_rst_r;
		end
	end
endmodule

//--- pgc_pin_ctrl_chk.sv
// Purpose: port checker for the pin, gpio and interrupt control block
// Assumes: control registers are only changed through the register port
// Notes: shadows copy written registers; settle windows absorb latency
////////////////////////////////////////////////////////////
module pgc_pin_ctrl_chk #(
	parameter CW = 12
) (
	input wire clock,
	input wire rst_n,
	input wire chip_reset_n,
	input wire [4:0] reg_addr,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	input wire bus_power_sense_pin,
	input wire sof_wave,
	input wire [7:0] gen_inputs,
	input wire [7:0] gen_outputs,
	input wire dplus_pullup_en,
	input wire dplus_pulldown_en,
	input wire dminus_pulldown_en,
	input wire irq_o,
	input wire irq_oe,
	input wire aux_out,
	input wire operate
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int W0 = 2650; // pulse cycles per width code
	localparam int W1 = 1325;
	localparam int W2 = 650;
	localparam int W3 = 325;
	reg [7:0] usb_sh, cpu_sh, pin_sh, mode_sh, lo_sh, hi_sh; // shadows
	reg [CW-1:0] cnt_r; // length of the running pulse
	wire pulse_on; // edge mode pin at its active level
	////////////////////////////////////////////////////////////
	// shadows; chip reset wins over a write, as in the block
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{usb_sh, cpu_sh, pin_sh} <= 24'h000000;
			{mode_sh, lo_sh, hi_sh} <= 24'h000000;
		end else begin
			if (reg_wr) begin
				case (reg_addr)
				5'h0f: usb_sh <= reg_wdata;
				5'h10: cpu_sh <= reg_wdata;
				5'h11: pin_sh <= reg_wdata;
				5'h14: lo_sh <= reg_wdata;
				5'h15: hi_sh <= reg_wdata;
				5'h1b: mode_sh <= reg_wdata;
				default: ;
				endcase
			end
			if (!chip_reset_n) begin
				{cpu_sh, mode_sh, lo_sh, hi_sh} <= 32'h00000000;
			end
		end
	end
	assign pulse_on = irq_oe && !pin_sh[3] && cpu_sh[0] &&
		(irq_o == pin_sh[2]);
	// pulse length counter, cleared between pulses
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= {CW{1'b0}};
		end else begin
			cnt_r <= pulse_on ? cnt_r + 1'b1 : {CW{1'b0}};
		end
	end
	////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	pullup_gate_a:
	assert property (($stable(usb_sh) && $stable(bus_power_sense_pin))[*4]
		|-> dplus_pullup_en == (usb_sh[3] && (!usb_sh[6] ||
		bus_power_sense_pin))) else $error("pull-up state wrong");
	pulldown_bits_a:
	assert property (($stable(mode_sh) && mode_sh[0] && chip_reset_n)[*4]
		|-> {dminus_pulldown_en, dplus_pulldown_en} == mode_sh[7:6])
		else $error("pulldown state wrong");
	irq_idle_a:
	assert property ((!cpu_sh[0] && $stable(pin_sh))[*3] |-> (pin_sh[3] ?
		!irq_oe : (irq_oe && irq_o == !pin_sh[2])))
		else $error("disabled interrupt pin not idle");
	level_low_a:
	assert property (pin_sh[3] && $past(pin_sh[3]) |-> !(irq_oe && irq_o))
		else $error("level mode drove the pin high");
	pulse_min_a:
	assert property ($fell(pulse_on) && $past(cpu_sh, 2) == cpu_sh &&
		$past(pin_sh, 2) == pin_sh |-> int'(cnt_r) >= (cpu_sh[7] ?
		(cpu_sh[6] ? W3 : W2) : (cpu_sh[6] ? W1 : W0)))
		else $error("interrupt pulse too short");
	gpio_out_a:
	assert property ($stable({hi_sh, lo_sh, chip_reset_n})[*4]
		|-> gen_outputs == {hi_sh[3:0], lo_sh[3:0]})
		else $error("general outputs differ from stored bits");
	io_read_a:
	assert property ((reg_addr == 5'h14 && !reg_wr && $stable(chip_reset_n)
		&& $stable(gen_inputs))[*4] |=> reg_rdata ==
		{$past(gen_inputs[3:0]), lo_sh[3:0]})
		else $error("low pin register read wrong");
	unmapped_a:
	assert property (reg_addr == 5'h12 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	aux_power_a:
	assert property ((pin_sh[1:0] == 2'h1 && $stable(pin_sh) &&
		$stable(bus_power_sense_pin))[*4] |-> aux_out == bus_power_sense_pin)
		else $error("aux does not show bus power");
	aux_operate_a:
	assert property ((pin_sh[1:0] == 2'h0 && $stable(pin_sh) &&
		$stable(operate))[*3] |-> aux_out == operate)
		else $error("aux does not show operate");
	operate_low_a:
	assert property ((!chip_reset_n)[*3] |-> !operate)
		else $error("operate high in chip reset");
	cover property ($fell(pulse_on));
	cover property (pin_sh[3] && irq_oe);
	cover property (pin_sh[1:0] == 2'h3 && $rose(sof_wave));
	cover property ($rose(chip_reset_n));
endmodule
bind pgc_pin_ctrl pgc_pin_ctrl_chk #(.CW(CW)) u_pgc_pin_ctrl_chk (.clock,
	.rst_n, .chip_reset_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
	.bus_power_sense_pin, .sof_wave, .gen_inputs, .gen_outputs,
	.dplus_pullup_en, .dplus_pulldown_en, .dminus_pulldown_en, .irq_o,
	.irq_oe, .aux_out, .operate);
